/* File: src/ssc_top.sv */
// Supply switch control: lock, key, switching, interrupt, backup gating
//
// Functional notes
// (R1) One select drives both digital and analog rail switches.
// (R2) Start-up occurs from primary or first backup supply.
// (R3) At start-up the higher of primary and first backup is chosen.
// (R4) Brownout reset sets the configuration lock.
// (R5) Key 0xA5 in control 0 unlocks control 1 and 2.
// (R6) Key field writable only while lock clear; key and lock in one write.
// (R7) While locked the start-up supply stays selected.
// (R8) Unlocked, switching follows software changes or monitor trigger.
// (R9) Software-mode bit per supply: 0 primary, 1 first, 2 second backup.
// (R10) Setting a valid bit switches immediately, subject to priority.
// (R11) Priority primary, first, second; raise bit lifts second above first.
// (R12) Active software supply losing valid moves to next by priority.
// (R13) Each rail switch raises an interrupt event.
// (R14) All supplies in software mode: monitor trigger ignored.
// (R15) Software disables unused backups by mode 1, valid 0.
// (R16) Supervisor off blocks backup-domain setting writes and reads.
// (R17) Hardware owns valid bit when its software-mode bit is 0.
// (R18) On backup, primary valid rising returns to primary at once.
// (R19) Control 1 and 2 ignore writes while locked.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssc_top (
    // Clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Analog side pins
    input wire logic I_PRI_PRESENT,
    input wire logic I_BK1_PRESENT,
    input wire logic I_BK1_HIGHER,
    input wire logic [2:0] I_HW_VALID,
    input wire logic I_MON_TRIG,
    input wire logic I_SUPERVISOR_ON,
    // Backup domain access requests
    input wire logic I_BAK_XTAL_WR,
    input wire logic I_BAK_RD,
    // Outputs
    output logic [1:0] O_RAIL_SEL,
    output logic O_RUN,
    output logic O_BAK_XTAL_WR,
    output logic O_BAK_RD_EN,
    output logic O_IRQ
);
    // Synchronised pins
    logic [9:0] pin_meta;
    logic [9:0] pin_sync;
    logic pri_present;
    logic bk1_present;
    logic bk1_higher;
    logic [2:0] hw_valid;
    logic mon_trig;
    logic sup_on;
    logic bak_wr;
    logic bak_rd;
    logic mon_trig_d;

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_meta <= 10'h000;
            pin_sync <= 10'h000;
        end else if (I_CE) begin
            // No gate ahead of the flops: a glitching OR could be caught mid-change
            pin_meta <= {I_BAK_RD, I_BAK_XTAL_WR, I_SUPERVISOR_ON, I_MON_TRIG,
                         I_HW_VALID, I_BK1_HIGHER, I_BK1_PRESENT, I_PRI_PRESENT};
            pin_sync <= pin_meta;
        end
    end
    assign pri_present = pin_sync[0];
    assign bk1_present = pin_sync[1];
    assign bk1_higher = pin_sync[2];
    assign hw_valid = pin_sync[5:3];
    assign mon_trig = pin_sync[6];
    assign sup_on = pin_sync[7];
    assign bak_wr = pin_sync[8];
    assign bak_rd = pin_sync[9];

    // Registers
    logic lock;
    logic [7:0] key;
    logic [2:0] mode;
    logic prio_raise;
    logic [2:0] sw_valid;
    logic [2:0] valid;
    logic [2:0] valid_d;
    logic started;
    logic [1:0] sel;
    logic irq_stat;
    logic irq_mask;

    // Bus decode
    logic wb_req;
    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_irq;
    logic [31:0] rd_mux;

    assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wr_ctl0 = wb_req && I_WB_WE && I_WB_ADR == ssc_pkg::OFS_CTL0;
    assign wr_ctl1 = wb_req && I_WB_WE && I_WB_ADR == ssc_pkg::OFS_CTL1 && !lock; // R19
    assign wr_ctl2 = wb_req && I_WB_WE && I_WB_ADR == ssc_pkg::OFS_CTL2 && !lock; // R19
    assign wr_irq = wb_req && I_WB_WE && I_WB_ADR == ssc_pkg::OFS_IRQ_STAT;

    // Effective validity: hardware owns bits not in software mode
    genvar gi;
    generate
        for (gi = 0; gi < ssc_pkg::NSUP; gi++) begin : g_valid
            assign valid[gi] = mode[gi] ? sw_valid[gi] : hw_valid[gi]; // R17
        end
    endgenerate

    // Lock and key; single write may carry both
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lock <= 1'b1; // R4
            key <= 8'h00;
        end else if (I_CE && wr_ctl0) begin
            if (I_WB_SEL[1] && (!lock || !I_WB_DAT[ssc_pkg::LOCK_BIT])) begin
                key <= I_WB_DAT[ssc_pkg::KEY_LSB +: ssc_pkg::KEY_W]; // R6
            end
            if (I_WB_SEL[0]) begin
                if (I_WB_DAT[ssc_pkg::LOCK_BIT]) begin
                    lock <= 1'b1;
                end else if (I_WB_SEL[1]
                             && I_WB_DAT[ssc_pkg::KEY_LSB +: ssc_pkg::KEY_W]
                                == ssc_pkg::UNLOCK_KEY) begin
                    lock <= 1'b0; // R5 R6
                end
            end
        end
    end

    // Control 1: software mode bits and priority raise
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mode <= ssc_pkg::MODE_RST;
            prio_raise <= 1'b0;
        end else if (I_CE && wr_ctl1) begin
            if (I_WB_SEL[0]) begin
                mode <= I_WB_DAT[ssc_pkg::MODE_LSB +: ssc_pkg::NSUP]; // R9
            end
            if (I_WB_SEL[1]) begin
                prio_raise <= I_WB_DAT[ssc_pkg::PRIO_BIT]; // R11
            end
        end
    end

    // Control 2: software valid bits, only where software owns the bit
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sw_valid <= ssc_pkg::VALID_RST;
        end else if (I_CE && wr_ctl2 && I_WB_SEL[0]) begin
            sw_valid <= (I_WB_DAT[ssc_pkg::VALID_LSB +: ssc_pkg::NSUP] & mode)
                        | (sw_valid & ~mode); // R17
        end
    end

    // Next-supply search
    logic [1:0] best_sel;
    logic best_found;
    logic [1:0] next_alt;
    logic alt_found;

    ssc_next_sel u_best (
        .i_valid(valid),
        .i_prio_raise(prio_raise),
        .i_exclude(sel),
        .i_use_exclude(1'b0),
        .o_sel(best_sel),
        .o_found(best_found)
    );
    ssc_next_sel u_alt (
        .i_valid(valid),
        .i_prio_raise(prio_raise),
        .i_exclude(sel),
        .i_use_exclude(1'b1),
        .o_sel(next_alt),
        .o_found(alt_found)
    );

    // Switching decision
    logic [2:0] valid_rise;
    logic all_sw;
    logic trig_edge;
    logic [1:0] next_sel;
    logic switch_now;

    assign valid_rise = valid & ~valid_d;
    assign all_sw = &mode;
    assign trig_edge = mon_trig && !mon_trig_d && !all_sw; // R14
    always_comb begin
        next_sel = sel;
        if (!started) begin
            // Backup alone, or clearly higher than primary
            next_sel = (bk1_present && (bk1_higher || !pri_present))
                       ? ssc_pkg::SSC_SEL_BK1 : ssc_pkg::SSC_SEL_PRI; // R3
        end else if (lock) begin
            next_sel = sel; // R7
        end else if (sel != ssc_pkg::SSC_SEL_PRI && valid_rise[ssc_pkg::SSC_SEL_PRI]) begin
            next_sel = ssc_pkg::SSC_SEL_PRI; // R18
        end else if ((|(valid_rise & mode)) && best_found) begin
            next_sel = best_sel; // R10 R11
        end else if (mode[sel] && !valid[sel] && valid_d[sel] && alt_found) begin
            next_sel = next_alt; // R12
        end else if (trig_edge && alt_found) begin
            next_sel = next_alt; // R8
        end
    end
    assign switch_now = started && next_sel != sel;

    // Rail select and start-up
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            started <= 1'b0;
            sel <= ssc_pkg::SSC_SEL_PRI;
            valid_d <= 3'h0;
            mon_trig_d <= 1'b0;
        end else if (I_CE) begin
            if (pri_present || bk1_present) begin
                started <= 1'b1; // R2
            end
            sel <= next_sel; // R1
            valid_d <= valid;
            mon_trig_d <= mon_trig;
        end
    end

    // Interrupt status, write one to clear; set wins
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            irq_stat <= 1'b0;
            irq_mask <= 1'b0;
        end else if (I_CE) begin
            if (switch_now) begin
                irq_stat <= 1'b1; // R13
            end else if (wr_irq && I_WB_SEL[0] && I_WB_DAT[ssc_pkg::STAT_BIT]) begin
                irq_stat <= 1'b0;
            end
            if (wr_irq && I_WB_SEL[2]) begin
                irq_mask <= I_WB_DAT[ssc_pkg::MASK_BIT];
            end
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (I_WB_ADR)
            ssc_pkg::OFS_CTL0: begin
                rd_mux[ssc_pkg::LOCK_BIT] = lock;
                rd_mux[ssc_pkg::SEL_LSB +: 2] = sel;
            end
            ssc_pkg::OFS_CTL1: begin
                rd_mux[ssc_pkg::MODE_LSB +: ssc_pkg::NSUP] = mode;
                rd_mux[ssc_pkg::PRIO_BIT] = prio_raise;
            end
            ssc_pkg::OFS_CTL2: begin
                rd_mux[ssc_pkg::VALID_LSB +: ssc_pkg::NSUP] = valid;
            end
            ssc_pkg::OFS_IRQ_STAT: begin
                rd_mux[ssc_pkg::STAT_BIT] = irq_stat;
                rd_mux[ssc_pkg::MASK_BIT] = irq_mask;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Bus answer one cycle after request
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end else if (I_CE) begin
            O_WB_ACK <= wb_req;
            if (wb_req && !I_WB_WE) begin
                O_WB_DAT <= rd_mux;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RAIL_SEL <= ssc_pkg::SSC_SEL_PRI;
            O_RUN <= 1'b0;
            O_BAK_XTAL_WR <= 1'b0;
            O_BAK_RD_EN <= 1'b0;
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_RAIL_SEL <= next_sel; // R1
            O_RUN <= started;
            O_BAK_XTAL_WR <= bak_wr && sup_on; // R16
            O_BAK_RD_EN <= bak_rd && sup_on; // R16
            O_IRQ <= (irq_stat || switch_now) && irq_mask;
        end
    end

    // Assertions
    a_lock_blocks_ctl1: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R19
        (I_CE && lock && wb_req && I_WB_WE && I_WB_ADR == ssc_pkg::OFS_CTL1)
        |=> $stable(mode)) else $error("control 1 changed while locked");
    a_locked_sel_hold: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R7
        (I_CE && started && lock) |=> $stable(sel))
        else $error("rail changed while locked");
    a_switch_irq: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R13
        (I_CE && switch_now) |=> irq_stat)
        else $error("switch raised no status");
    a_hw_valid_owned: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R17
        (I_CE && !mode[0]) |-> valid[0] == hw_valid[0])
        else $error("software overrode hardware valid");
    a_backup_gate: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R16
        (I_CE && !sup_on) |=> !O_BAK_RD_EN && !O_BAK_XTAL_WR)
        else $error("backup access while supervisor off");
    a_rail_follows: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R1
        I_CE |=> O_RAIL_SEL == sel)
        else $error("rail output differs from select");
    a_pri_return: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R18
        (I_CE && started && !lock && sel != ssc_pkg::SSC_SEL_PRI
         && valid_rise[ssc_pkg::SSC_SEL_PRI]) |=> sel == ssc_pkg::SSC_SEL_PRI)
        else $error("no return to primary");
    a_trig_ignored: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R14
        (I_CE && started && all_sw && valid == valid_d) |=> $stable(sel))
        else $error("monitor switched in software mode");
    a_key_unlock: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R5
        (I_CE && wr_ctl0 && I_WB_SEL[0] && I_WB_SEL[1] && !I_WB_DAT[ssc_pkg::LOCK_BIT]
         && I_WB_DAT[ssc_pkg::KEY_LSB +: ssc_pkg::KEY_W] == ssc_pkg::UNLOCK_KEY) |=> !lock)
        else $error("correct key left the lock set");
    a_bad_key_keeps: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R6
        (I_CE && lock && wr_ctl0
         && I_WB_DAT[ssc_pkg::KEY_LSB +: ssc_pkg::KEY_W] != ssc_pkg::UNLOCK_KEY) |=> lock)
        else $error("wrong key cleared the lock");
    a_start_on_power: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N) // R2
        (I_CE && (pri_present || bk1_present)) |=> started)
        else $error("no start-up with a supply present");
endmodule : ssc_top
`default_nettype wire

/* File: src/ssc_pkg.sv */
// Constants, register map and types of the supply switch control
package ssc_pkg;
    localparam int ADDR_W = 4;
    // Register word offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTL0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTL1 = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CTL2 = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'hC;
    // Control 0 fields
    localparam int KEY_LSB = 8;
    localparam int KEY_W = 8;
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam int LOCK_BIT = 0;
    localparam int SEL_LSB = 4;
    // Control 1 fields: software mode bits 0..2, priority raise bit 8
    localparam int MODE_LSB = 0;
    localparam int PRIO_BIT = 8;
    // Control 2 fields: valid bits 0..2
    localparam int VALID_LSB = 0;
    // Status/mask word: status bit 0, mask bit 16
    localparam int STAT_BIT = 0;
    localparam int MASK_BIT = 16;
    localparam int NSUP = 3;
    localparam logic [NSUP-1:0] MODE_RST = 3'h0;
    localparam logic [NSUP-1:0] VALID_RST = 3'h0;
    // Supply select codes
    typedef enum logic [1:0] {
        SSC_SEL_PRI = 2'h0,
        SSC_SEL_BK1 = 2'h1,
        SSC_SEL_BK2 = 2'h2
    } ssc_sel_t;
endpackage : ssc_pkg

/* File: src/ssc_next_sel.sv */
// Next-supply selection by validity and priority
`timescale 1ns/1ps
`default_nettype none
module ssc_next_sel (
    // Validity and priority
    input wire logic [2:0] i_valid,
    input wire logic i_prio_raise,
    // Current and excluded supply
    input wire logic [1:0] i_exclude,
    input wire logic i_use_exclude,
    // Result
    output logic [1:0] o_sel,
    output logic o_found
);
    logic [2:0] cand;
    always_comb begin
        cand = i_valid;
        if (i_use_exclude) begin
            cand[i_exclude] = 1'b0;
        end
        o_found = 1'b1;
        if (cand[ssc_pkg::SSC_SEL_PRI]) begin
            o_sel = ssc_pkg::SSC_SEL_PRI;
        end else if (cand[ssc_pkg::SSC_SEL_BK2] && (i_prio_raise || !cand[ssc_pkg::SSC_SEL_BK1])) begin
            o_sel = ssc_pkg::SSC_SEL_BK2;
        end else if (cand[ssc_pkg::SSC_SEL_BK1]) begin
            o_sel = ssc_pkg::SSC_SEL_BK1;
        end else begin
            o_sel = ssc_pkg::SSC_SEL_PRI;
            o_found = 1'b0;
        end
    end
endmodule : ssc_next_sel
`default_nettype wire

/* File: test/ssc_supply_model.sv */
// Far-side model: supply presence, hardware validity, monitor trigger
`timescale 1ns/1ps
`default_nettype none
module ssc_supply_model (
    // Clock
    input wire logic i_clk,
    // Supply pins
    output logic o_pri_present,
    output logic o_bk1_present,
    output logic o_bk1_higher,
    output logic [2:0] o_hw_valid,
    output logic o_mon_trig
);
    // Both supplies present at power-on, first backup clearly higher
    initial begin
        o_pri_present = 1'b1;
        o_bk1_present = 1'b1;
        o_bk1_higher = 1'b1;
        o_hw_valid = 3'h0;
        o_mon_trig = 1'b0;
    end
    task automatic set_valid(input logic [2:0] v);
        @(posedge i_clk);
        o_hw_valid <= v;
    endtask : set_valid
    // Held for several cycles so the two-flop synchroniser cannot miss it
    task automatic mon_pulse();
        @(posedge i_clk);
        o_mon_trig <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_mon_trig <= 1'b0;
    endtask : mon_pulse
endmodule : ssc_supply_model
`default_nettype wire

/* File: test/ssc_top_tb.sv */
// Testbench of the supply switch control
`timescale 1ns/1ps
`default_nettype none
module ssc_top_tb;
    logic clk, rst_n, cyc, stb, we, sup_on, xtal_wr, bak_rd, ack, run, bak_xtal, bak_rd_en, irq;
    logic pri_p, bk1_p, bk1_hi, trig;
    logic ce;
    logic [3:0] adr, be;
    logic [31:0] wdat, rdat, q;
    logic [2:0] hw_valid;
    logic [1:0] sel;
    int failures, check_count;

    ssc_top i_ssc_top (.I_MCLK(clk), .I_ARST_N(rst_n), .I_CE(ce),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(be),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_PRI_PRESENT(pri_p), .I_BK1_PRESENT(bk1_p), .I_BK1_HIGHER(bk1_hi),
        .I_HW_VALID(hw_valid), .I_MON_TRIG(trig), .I_SUPERVISOR_ON(sup_on),
        .I_BAK_XTAL_WR(xtal_wr), .I_BAK_RD(bak_rd), .O_RAIL_SEL(sel), .O_RUN(run),
        .O_BAK_XTAL_WR(bak_xtal), .O_BAK_RD_EN(bak_rd_en), .O_IRQ(irq));

    ssc_supply_model i_ssc_supply_model (.i_clk(clk), .o_pri_present(pri_p),
        .o_bk1_present(bk1_p), .o_bk1_higher(bk1_hi), .o_hw_valid(hw_valid),
        .o_mon_trig(trig));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Classic cycle; the slave's answer time is never assumed
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            end_sim();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, q & m, e);
    endtask : rdm

    // A hold check waits first so a wrong switch has time to show
    task automatic wsel(input logic [1:0] e, input logic stay);
        int n;
        n = 0;
        if (stay) repeat (12) @(posedge clk);
        while (sel !== e && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("rail_sel", 32'(sel), 32'(e));
    endtask : wsel

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        be = 4'hF;
        ce = 1'b1;
        wdat = 32'h0000_0000;
        sup_on = 1'b1;
        xtal_wr = 1'b0;
        bak_rd = 1'b0;
        failures = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b0);
        // Run flag registers one cycle behind the select
        @(posedge clk);
        chk("run", 32'(run), 32'h0000_0001);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0031, 32'h0000_0011, "ctl0_reset");
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h0000_0107);
        rdm(ssc_pkg::OFS_CTL1, 32'h0000_0107, 32'h0000_0000, "ctl1_locked");
        wb(1'b1, ssc_pkg::OFS_CTL0, 32'h0000_5A00);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0001, 32'h0000_0001, "lock_bad_key");
        wb(1'b1, ssc_pkg::OFS_CTL0, 32'h0000_A501);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0001, 32'h0000_0001, "lock_set_key");
        i_ssc_supply_model.mon_pulse();
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b1);
        wb(1'b1, ssc_pkg::OFS_CTL0, 32'h0000_A500);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0001, 32'h0000_0000, "lock_clear");
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h0000_0007);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0004);
        wsel(ssc_pkg::SSC_SEL_BK2, 1'b0);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0006);
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b0);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0004);
        wsel(ssc_pkg::SSC_SEL_BK2, 1'b0);
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h0000_0107);
        rdm(ssc_pkg::OFS_CTL1, 32'h0000_0107, 32'h0000_0107, "ctl1_open");
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0006);
        wsel(ssc_pkg::SSC_SEL_BK2, 1'b1);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0007);
        wsel(ssc_pkg::SSC_SEL_PRI, 1'b0);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0006);
        wsel(ssc_pkg::SSC_SEL_BK2, 1'b0);
        i_ssc_supply_model.mon_pulse();
        wsel(ssc_pkg::SSC_SEL_BK2, 1'b1);
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h0000_0003);
        i_ssc_supply_model.set_valid(3'h4);
        repeat (4) @(posedge clk);
        rdm(ssc_pkg::OFS_CTL2, 32'h0000_0007, 32'h0000_0006, "valid_mix");
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0000);
        rdm(ssc_pkg::OFS_CTL2, 32'h0000_0007, 32'h0000_0004, "valid_hw_owned");
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0001);
        wsel(ssc_pkg::SSC_SEL_PRI, 1'b0);
        wb(1'b1, ssc_pkg::OFS_CTL2, 32'h0000_0003);
        wsel(ssc_pkg::SSC_SEL_PRI, 1'b1);
        wb(1'b1, ssc_pkg::OFS_IRQ_STAT, 32'h0000_0001);
        rdm(ssc_pkg::OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0000, "stat_clear");
        i_ssc_supply_model.mon_pulse();
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b0);
        rdm(ssc_pkg::OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, "stat_set");
        chk("irq_masked", 32'(irq), 32'h0000_0000);
        wb(1'b1, ssc_pkg::OFS_IRQ_STAT, 32'h0001_0000);
        repeat (3) @(posedge clk);
        chk("irq_on", 32'(irq), 32'h0000_0001);
        wb(1'b1, ssc_pkg::OFS_IRQ_STAT, 32'h0001_0001);
        repeat (3) @(posedge clk);
        chk("irq_off", 32'(irq), 32'h0000_0000);
        // Trigger while frozen must be lost, not acted on later
        ce <= 1'b0;
        i_ssc_supply_model.mon_pulse();
        ce <= 1'b1;
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b1);
        sup_on <= 1'b0;
        xtal_wr <= 1'b1;
        bak_rd <= 1'b1;
        repeat (6) @(posedge clk);
        chk("bak_gated", {30'h0, bak_xtal, bak_rd_en}, 32'h0000_0000);
        sup_on <= 1'b1;
        repeat (6) @(posedge clk);
        chk("bak_open", {30'h0, bak_xtal, bak_rd_en}, 32'h0000_0003);
        wb(1'b1, ssc_pkg::OFS_CTL0, 32'h0000_0001);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0001, 32'h0000_0001, "relock");
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h0000_0000);
        rdm(ssc_pkg::OFS_CTL1, 32'h0000_0107, 32'h0000_0003, "ctl1_relock");
        // Key byte alone, lock byte not enabled: lock must stay
        be <= 4'h2;
        wb(1'b1, ssc_pkg::OFS_CTL0, 32'h0000_A500);
        be <= 4'hF;
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0001, 32'h0000_0001, "lock_byte_off");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wsel(ssc_pkg::SSC_SEL_BK1, 1'b0);
        rdm(ssc_pkg::OFS_CTL0, 32'h0000_0031, 32'h0000_0011, "ctl0_rerun");
        rdm(ssc_pkg::OFS_CTL1, 32'h0000_0107, 32'h0000_0000, "ctl1_rerun");
        end_sim();
    end
endmodule : ssc_top_tb
`default_nettype wire
